/* hw/fault_sup_pkg.sv */
// fault_sup_pkg: constants and carrier types for the supply and thermal fault supervisor
// assumes one 20 MHz clock; comparator and sensor inputs already filtered and synchronous

package fault_sup_pkg;
    localparam int unsigned clk_hz = 20_000_000;
    localparam int unsigned short_filter_us = 4000;
    localparam int unsigned short_filter_cycles = short_filter_us * (clk_hz / 1_000_000);
    localparam int unsigned cool_down_us = 1000;
    localparam int unsigned cool_down_cycles = cool_down_us * (clk_hz / 1_000_000);
    localparam int unsigned restart_us = 2000;
    localparam int unsigned restart_cycles = restart_us * (clk_hz / 1_000_000);
    localparam logic [1:0] fail_none = 2'h0;
    localparam logic [1:0] fail_overtemp = 2'h1;
    localparam int unsigned hs_count = 4;

    typedef enum logic [2:0] {
        mode_normal = 3'h1,
        mode_fail_safe = 3'h2,
        mode_restart = 3'h4
    } chip_mode_type;

    // host clear strobes, one bit per status field; the highside bit clears all four
    typedef struct packed {
        logic main_short;
        logic second_uv;
        logic can_uv;
        logic ext_uv;
        logic ext_oc;
        logic block_tsd;
        logic second_ot;
        logic ext_ot;
        logic can_fault;
        logic lin_one;
        logic lin_two;
        logic highside;
        logic prewarn;
        logic chip_tsd;
        logic fail;
    } clear_type;

    // sticky status flags
    typedef struct packed {
        logic main_short;
        logic second_uv;
        logic can_uv;
        logic ext_uv;
        logic ext_oc;
        logic block_tsd;
        logic second_ot;
        logic ext_ot;
        logic [1:0] can_fault;
        logic [1:0] lin_one;
        logic [1:0] lin_two;
        logic [3:0] highside;
        logic prewarn;
        logic chip_tsd;
        logic fail;
    } status_type;
endpackage : fault_sup_pkg

/* hw/sticky_flag.sv */
// sticky_flag: one hardware-set, host-cleared flag
// assumes set and clear are synchronous strobes or levels
`timescale 1ns/1ns
`default_nettype none
module sticky_flag (
    input wire logic clk,
    input wire logic resetn,
    input wire logic set,
    input wire logic clear,
    input wire logic clear_allowed,
    output logic flag
);
    logic next_flag;
    // set wins over clear; clear only when allowed
    always_comb begin
        next_flag = flag;
        if (clear && clear_allowed) begin
            next_flag = 1'b0;
        end
        if (set) begin
            next_flag = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end
    a_flag_holds: assert property (@(posedge clk) disable iff (!resetn)
        flag && !clear |=> flag) else $error("sticky flag dropped");
endmodule // sticky_flag
`default_nettype wire

/* hw/fault_timer.sv */
// fault_timer: counts while a condition holds, pulses done once on reaching the limit
// assumes cond is synchronous to clk
`timescale 1ns/1ns
`default_nettype none
module fault_timer #(
    parameter int unsigned limit = 80000
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cond,
    output logic done
);
    logic [31:0] count;
    logic [31:0] next_count;
    always_comb begin
        next_count = count;
        if (!cond) begin
            next_count = 32'h0;
        end else if (count < limit) begin
            next_count = count + 32'h1;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count <= 32'h0;
        end else begin
            count <= next_count;
        end
    end
    assign done = cond && (count == limit - 1);
endmodule // fault_timer
`default_nettype wire

/* hw/supply_thermal_fault_supervisor.sv */
// supply_thermal_fault_supervisor: fault flags, shutdowns and mode moves of the supply block
// assumes comparator and sensor inputs are filtered and synchronous to clk
`timescale 1ns/1ns
`default_nettype none
module supply_thermal_fault_supervisor #(
    parameter int unsigned short_filter = fault_sup_pkg::short_filter_cycles,
    parameter int unsigned cool_down = fault_sup_pkg::cool_down_cycles,
    parameter int unsigned restart_time = fault_sup_pkg::restart_cycles
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic main_above_reset,
    input wire logic main_powering_up,
    input wire logic battery_undervolt,
    input wire logic can_wake,
    input wire logic lin_wake,
    input wire logic wake_input_pins,
    input wire logic stop_mode,
    input wire logic loadshare_config,
    input wire logic ext_reg_undervolt_keep_on,
    input wire logic loadshare_stop_keep_on,
    input wire logic ext_overcurrent,
    input wire logic ext_undervolt,
    input wire logic ext_turning_on,
    input wire logic second_undervolt,
    input wire logic second_switching,
    input wire logic can_undervolt,
    input wire logic second_hot,
    input wire logic ext_hot,
    input wire logic can_hot,
    input wire logic lin_one_hot,
    input wire logic lin_two_hot,
    input wire logic [3:0] highside_hot,
    input wire logic prewarn_hot,
    input wire logic chip_hot,
    input wire logic second_enable_write,
    input wire logic [1:0] second_enable_data,
    input wire logic ext_enable_write,
    input wire logic [1:0] ext_enable_data,
    input wire logic highside_write,
    input wire logic [3:0] highside_data,
    input wire logic can_tx_request,
    input wire logic lin_one_tx_request,
    input wire logic lin_two_tx_request,
    input wire fault_sup_pkg::clear_type clear,
    output fault_sup_pkg::status_type status,
    output fault_sup_pkg::chip_mode_type mode,
    output logic main_reg_on,
    output logic fail_output_pins,
    output logic [1:0] second_reg_enable_field,
    output logic second_reg_on,
    output logic [1:0] ext_reg_enable_field,
    output logic ext_reg_on,
    output logic can_tx_on,
    output logic lin_one_tx_on,
    output logic lin_two_tx_on,
    output logic [3:0] highside_switches
);
    // ----------------------------------------
    // main regulator short supervision
    // ----------------------------------------
    logic short_cond;
    logic short_done;
    logic cool_done;
    logic restart_done;
    logic bus_wake;
    logic chip_event;
    logic short_latched;
    logic next_short_latched;
    logic main_on;
    logic next_main_on;
    fault_sup_pkg::chip_mode_type next_mode;

    // below threshold at power up or later, with battery ok
    assign short_cond = main_on && !main_above_reset && !battery_undervolt;
    assign bus_wake = can_wake || lin_wake || wake_input_pins;
    assign chip_event = chip_hot && main_on;

    fault_timer #(.limit(short_filter)) u_short_timer (
        .clk(clk),
        .resetn(resetn),
        .cond(short_cond),
        .done(short_done)
    );
    fault_timer #(.limit(cool_down)) u_cool_timer (
        .clk(clk),
        .resetn(resetn),
        .cond(mode == fault_sup_pkg::mode_fail_safe && !short_latched),
        .done(cool_done)
    );
    fault_timer #(.limit(restart_time)) u_restart_timer (
        .clk(clk),
        .resetn(resetn),
        .cond(mode == fault_sup_pkg::mode_restart),
        .done(restart_done)
    );

    // ----------------------------------------
    // mode sequencing
    // ----------------------------------------
    always_comb begin
        next_mode = mode;
        next_short_latched = short_latched;
        next_main_on = main_on;
        case (mode)
            fault_sup_pkg::mode_normal: begin
                if (short_done) begin
                    next_mode = fault_sup_pkg::mode_fail_safe;
                    next_short_latched = 1'b1;
                    next_main_on = 1'b0;
                end else if (chip_event) begin
                    next_mode = fault_sup_pkg::mode_fail_safe;
                end
            end
            fault_sup_pkg::mode_fail_safe: begin
                if (short_done) begin
                    next_short_latched = 1'b1;
                    next_main_on = 1'b0;
                end else if (short_latched) begin
                    if (bus_wake) begin
                        next_mode = fault_sup_pkg::mode_restart;
                        next_short_latched = 1'b0;
                        next_main_on = 1'b1;
                    end
                end else if (cool_done) begin
                    next_mode = fault_sup_pkg::mode_restart;
                end
            end
            fault_sup_pkg::mode_restart: begin
                if (short_done) begin
                    next_mode = fault_sup_pkg::mode_fail_safe;
                    next_short_latched = 1'b1;
                    next_main_on = 1'b0;
                end else if (restart_done) begin
                    next_mode = fault_sup_pkg::mode_normal;
                end
            end
            default: begin
                next_mode = fault_sup_pkg::mode_normal;
            end
        endcase
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode <= fault_sup_pkg::mode_normal;
            short_latched <= 1'b0;
            main_on <= 1'b1;
        end else begin
            mode <= next_mode;
            short_latched <= next_short_latched;
            main_on <= next_main_on;
        end
    end
    assign main_reg_on = main_on;
    assign fail_output_pins = (mode == fault_sup_pkg::mode_fail_safe);

    // ----------------------------------------
    // enables cleared by overtemperature
    // ----------------------------------------
    logic second_ot_event;
    logic ext_ot_event;
    logic hs_ot_event;
    logic [1:0] next_second_field;
    logic [1:0] next_ext_field;
    logic [3:0] next_hs;

    assign second_ot_event = second_hot && |second_reg_enable_field;
    assign ext_ot_event = ext_hot && |ext_reg_enable_field;
    assign hs_ot_event = |(highside_hot & highside_switches);

    always_comb begin
        next_second_field = second_enable_write ? second_enable_data : second_reg_enable_field;
        next_ext_field = ext_reg_enable_field;
        next_hs = highside_switches;
        if (ext_enable_write) begin
            next_ext_field = ext_enable_data;
        end
        if (highside_write) begin
            next_hs = highside_data;
        end
        if (second_ot_event) begin
            next_second_field = 2'h0;
        end
        if (ext_ot_event && !loadshare_config) begin
            next_ext_field = 2'h0;
        end
        if (hs_ot_event) begin
            next_hs = 4'h0;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            second_reg_enable_field <= 2'h0;
            ext_reg_enable_field <= 2'h0;
            highside_switches <= 4'h0;
        end else begin
            second_reg_enable_field <= next_second_field;
            ext_reg_enable_field <= next_ext_field;
            highside_switches <= next_hs;
        end
    end

    assign second_reg_on = |second_reg_enable_field && !second_hot;
    // load sharing comes back by itself when cool; stand-alone waits for a write
    assign ext_reg_on = |ext_reg_enable_field && !ext_hot
        && !(battery_undervolt && !ext_reg_undervolt_keep_on)
        && !(loadshare_config && stop_mode && !loadshare_stop_keep_on);
    assign can_tx_on = can_tx_request && !can_hot;
    assign lin_one_tx_on = lin_one_tx_request && !lin_one_hot;
    assign lin_two_tx_on = lin_two_tx_request && !lin_two_hot;

    // ----------------------------------------
    // sticky status flags
    // ----------------------------------------
    logic normal;
    localparam logic [1:0] fail_overtemp = fault_sup_pkg::fail_overtemp;
    assign normal = (mode == fault_sup_pkg::mode_normal);

    sticky_flag u_f_short (.clk(clk), .resetn(resetn),
        .set(short_done && !main_powering_up), .clear(clear.main_short),
        .clear_allowed(1'b1), .flag(status.main_short));
    sticky_flag u_f_fail (.clk(clk), .resetn(resetn),
        .set(short_done), .clear(clear.fail), .clear_allowed(1'b1), .flag(status.fail));
    sticky_flag u_f_sec_uv (.clk(clk), .resetn(resetn),
        .set(second_undervolt && !second_switching), .clear(clear.second_uv),
        .clear_allowed(1'b1), .flag(status.second_uv));
    sticky_flag u_f_can_uv (.clk(clk), .resetn(resetn),
        .set(can_undervolt), .clear(clear.can_uv),
        .clear_allowed(1'b1), .flag(status.can_uv));
    sticky_flag u_f_ext_uv (.clk(clk), .resetn(resetn),
        .set(!loadshare_config && ext_undervolt && !ext_turning_on),
        .clear(clear.ext_uv), .clear_allowed(1'b1), .flag(status.ext_uv));
    sticky_flag u_f_ext_oc (.clk(clk), .resetn(resetn),
        .set(!loadshare_config && ext_overcurrent), .clear(clear.ext_oc),
        .clear_allowed(1'b1), .flag(status.ext_oc));
    sticky_flag u_f_block (.clk(clk), .resetn(resetn),
        .set(second_ot_event || ext_ot_event || hs_ot_event || (can_hot && can_tx_request)
            || (lin_one_hot && lin_one_tx_request) || (lin_two_hot && lin_two_tx_request)),
        .clear(clear.block_tsd), .clear_allowed(!(second_hot || ext_hot || can_hot
            || lin_one_hot || lin_two_hot || |highside_hot)), .flag(status.block_tsd));
    sticky_flag u_f_sec_ot (.clk(clk), .resetn(resetn),
        .set(second_ot_event), .clear(clear.second_ot),
        .clear_allowed(!second_hot), .flag(status.second_ot));
    sticky_flag u_f_ext_ot (.clk(clk), .resetn(resetn),
        .set(ext_ot_event), .clear(clear.ext_ot),
        .clear_allowed(!ext_hot), .flag(status.ext_ot));
    sticky_flag u_f_can (.clk(clk), .resetn(resetn),
        .set(can_hot && can_tx_request), .clear(clear.can_fault),
        .clear_allowed(!can_hot), .flag(status.can_fault[0]));
    sticky_flag u_f_lin1 (.clk(clk), .resetn(resetn),
        .set(lin_one_hot && lin_one_tx_request), .clear(clear.lin_one),
        .clear_allowed(!lin_one_hot), .flag(status.lin_one[0]));
    sticky_flag u_f_lin2 (.clk(clk), .resetn(resetn),
        .set(lin_two_hot && lin_two_tx_request), .clear(clear.lin_two),
        .clear_allowed(!lin_two_hot), .flag(status.lin_two[0]));
    assign status.can_fault[1] = fail_overtemp[1];
    assign status.lin_one[1] = fail_overtemp[1];
    assign status.lin_two[1] = fail_overtemp[1];

    genvar gi;
    generate
        for (gi = 0; gi < fault_sup_pkg::hs_count; gi++) begin : g_hs
            sticky_flag u_f_hs (.clk(clk), .resetn(resetn),
                .set(hs_ot_event), .clear(clear.highside),
                .clear_allowed(!(|highside_hot)), .flag(status.highside[gi]));
        end
    endgenerate

    sticky_flag u_f_pw (.clk(clk), .resetn(resetn),
        .set(prewarn_hot && main_on), .clear(clear.prewarn),
        .clear_allowed(!prewarn_hot), .flag(status.prewarn));
    sticky_flag u_f_chip_tsd (.clk(clk), .resetn(resetn),
        .set(chip_event), .clear(clear.chip_tsd),
        .clear_allowed(normal && !chip_hot), .flag(status.chip_tsd));

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_short_failsafe: assert property (@(posedge clk) disable iff (!resetn)
        short_done |=> mode == fault_sup_pkg::mode_fail_safe && !main_reg_on)
        else $error("short did not force fail-safe");
    a_short_wake: assert property (@(posedge clk) disable iff (!resetn)
        short_latched && !bus_wake |=> short_latched)
        else $error("left short fail-safe without wake");
    a_short_battery: assert property (@(posedge clk) disable iff (!resetn)
        battery_undervolt |-> !short_done)
        else $error("short filter ran in undervoltage");
    a_ext_uv_off: assert property (@(posedge clk) disable iff (!resetn)
        battery_undervolt && !ext_reg_undervolt_keep_on |-> !ext_reg_on)
        else $error("external regulator on in undervoltage");
    a_second_ot: assert property (@(posedge clk) disable iff (!resetn)
        second_ot_event |=> second_reg_enable_field == 2'h0 && status.second_ot)
        else $error("second regulator not shut down");
    a_can_tx: assert property (@(posedge clk) disable iff (!resetn)
        can_hot |-> !can_tx_on)
        else $error("can transmitter on while hot");
    a_hs_all_off: assert property (@(posedge clk) disable iff (!resetn)
        hs_ot_event |=> highside_switches == 4'h0 && &status.highside)
        else $error("high-side not all off");
    a_chip_thermal_shutdown_flag_enter: assert property (@(posedge clk) disable iff (!resetn)
        chip_event && normal && !short_done |=> mode == fault_sup_pkg::mode_fail_safe
        && status.chip_tsd)
        else $error("chip shutdown did not enter fail-safe");
    c_short: cover property (@(posedge clk) disable iff (!resetn) short_done);
    c_chip: cover property (@(posedge clk) disable iff (!resetn) chip_event);
    c_restart: cover property (@(posedge clk) disable iff (!resetn) restart_done);
endmodule // supply_thermal_fault_supervisor
`default_nettype wire

/* testbench/host_model.sv */
// host_model: host side of the fault supervisor, issues clear and write strobes
// assumes strobes are sampled on the rising clk edge after they are raised
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input wire logic clk,
    output var fault_sup_pkg::clear_type clear,
    output logic second_enable_write,
    output logic [1:0] second_enable_data,
    output logic ext_enable_write,
    output logic [1:0] ext_enable_data,
    output logic highside_write,
    output logic [3:0] highside_data
);
    initial begin
        clear = '0;
        {second_enable_write, second_enable_data, ext_enable_write, ext_enable_data} = '0;
        {highside_write, highside_data} = '0;
    end
    // one-cycle clear strobe
    task automatic clr(input fault_sup_pkg::clear_type c);
        @(posedge clk);
        #1 clear = c;
        @(posedge clk);
        #1 clear = '0;
    endtask
    // one-cycle write strobe: 0 second, 1 external, 2 high-side
    task automatic wr(input int k, input logic [3:0] d);
        @(posedge clk);
        #1 {second_enable_data, ext_enable_data, highside_data} = {d[1:0], d[1:0], d};
        {second_enable_write, ext_enable_write, highside_write} = {k == 0, k == 1, k == 2};
        @(posedge clk);
        #1 {second_enable_write, ext_enable_write, highside_write} = '0;
    endtask
    // flag cleared before the regulator is enabled again
    task automatic ext_reenable(input logic [1:0] d);
        clr('{ext_ot: 1'b1, default: 1'b0});
        wr(1, {2'h0, d});
    endtask
endmodule // host_model
`default_nettype wire

/* testbench/tb_supply_thermal_fault_supervisor.sv */
// tb_supply_thermal_fault_supervisor: self-checking bench for the fault supervisor
// assumes shortened counts: short filter 8, cool-down 4, restart 4 cycles
`timescale 1ns/1ns
`default_nettype none
module tb_supply_thermal_fault_supervisor;
    localparam int unsigned sf = 8;
    logic clk, resetn, main_above_reset, main_powering_up, battery_undervolt, seen;
    logic can_wake, lin_wake, wake_input_pins, stop_mode, loadshare_config;
    logic ext_reg_undervolt_keep_on, loadshare_stop_keep_on, ext_overcurrent, ext_undervolt;
    logic ext_turning_on, second_undervolt, second_switching, can_undervolt, second_hot;
    logic ext_hot, can_hot, lin_one_hot, lin_two_hot, prewarn_hot, chip_hot;
    logic can_tx_request, lin_one_tx_request, lin_two_tx_request;
    logic second_enable_write, ext_enable_write, highside_write;
    logic [1:0] second_enable_data, ext_enable_data, second_reg_enable_field, ext_reg_enable_field;
    logic [3:0] highside_hot, highside_data, highside_switches;
    logic main_reg_on, fail_output_pins, second_reg_on, ext_reg_on;
    logic can_tx_on, lin_one_tx_on, lin_two_tx_on;
    fault_sup_pkg::clear_type clear;
    fault_sup_pkg::status_type status;
    fault_sup_pkg::chip_mode_type mode;
    int err_total = 0;
    int cmp_count = 0;
    // load share, battery uv, stop, keep-on, stop keep-on, expected transistor on
    logic [5:0] rows [8] = '{6'h21, 6'h30, 6'h35, 6'h28, 6'h2b, 6'h01, 6'h10, 6'h15};

    supply_thermal_fault_supervisor #(.short_filter(sf), .cool_down(4), .restart_time(4))
        u_supply_thermal_fault_supervisor (.clk, .resetn, .main_above_reset, .main_powering_up,
        .battery_undervolt, .can_wake, .lin_wake, .wake_input_pins, .stop_mode,
        .loadshare_config, .ext_reg_undervolt_keep_on, .loadshare_stop_keep_on,
        .ext_overcurrent, .ext_undervolt, .ext_turning_on, .second_undervolt,
        .second_switching, .can_undervolt, .second_hot, .ext_hot, .can_hot, .lin_one_hot,
        .lin_two_hot, .highside_hot, .prewarn_hot, .chip_hot, .second_enable_write,
        .second_enable_data, .ext_enable_write, .ext_enable_data, .highside_write,
        .highside_data, .can_tx_request, .lin_one_tx_request, .lin_two_tx_request, .clear,
        .status, .mode, .main_reg_on, .fail_output_pins, .second_reg_enable_field,
        .second_reg_on, .ext_reg_enable_field, .ext_reg_on, .can_tx_on, .lin_one_tx_on,
        .lin_two_tx_on, .highside_switches);
    host_model u_host_model (.clk, .clear, .second_enable_write, .second_enable_data,
        .ext_enable_write, .ext_enable_data, .highside_write, .highside_data);

    // ----------------------------------------
    // clock, tasks and watchdog
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #(3000 * 50);
        err_total++;
        test_done;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {resetn, main_powering_up, battery_undervolt, can_wake, lin_wake, wake_input_pins} = '0;
        {stop_mode, loadshare_config, ext_reg_undervolt_keep_on, loadshare_stop_keep_on} = '0;
        {ext_overcurrent, ext_undervolt, ext_turning_on, second_undervolt, second_switching} = '0;
        {can_undervolt, second_hot, ext_hot, can_hot, lin_one_hot, lin_two_hot} = '0;
        {prewarn_hot, chip_hot, can_tx_request, lin_one_tx_request, lin_two_tx_request} = '0;
        {highside_hot, main_above_reset, seen} = 6'h02;
        step(6);
        resetn = 1'b1;
        u_host_model.wr(1, 4'h1);
        foreach (rows[i]) begin
            {loadshare_config, battery_undervolt, stop_mode, ext_reg_undervolt_keep_on,
                loadshare_stop_keep_on} = rows[i][5:1];
            step(2);
            chk(ext_reg_on === rows[i][0], "transistor enable row");
        end
        {loadshare_config, battery_undervolt, ext_reg_undervolt_keep_on} = '0;
        resetn = 1'b0;
        step(1);
        chk(mode === fault_sup_pkg::mode_normal && main_reg_on === 1'b1, "reset mode");
        chk(status === '0 && ext_reg_enable_field === 2'h0, "reset flags");
        resetn = 1'b1;
        second_hot = 1'b1;
        step(2);
        chk(status.second_ot === 1'b0 && status.block_tsd === 1'b0, "off stage hot");
        u_host_model.wr(0, 4'h1);
        step(2);
        chk(second_reg_enable_field === 2'h0 && second_reg_on === 1'b0, "second off");
        chk(status.second_ot === 1'b1 && status.block_tsd === 1'b1, "second flags");
        u_host_model.clr('{second_ot: 1'b1, block_tsd: 1'b1, default: 1'b0});
        chk(status.second_ot === 1'b1 && status.block_tsd === 1'b1, "clear while hot");
        second_hot = 1'b0;
        step(2);
        chk(second_reg_on === 1'b0 && status.second_ot === 1'b1, "stays off");
        u_host_model.clr('{second_ot: 1'b1, block_tsd: 1'b1, default: 1'b0});
        chk(status.second_ot === 1'b0 && status.block_tsd === 1'b0, "cleared cool");
        u_host_model.wr(1, 4'h1);
        {second_switching, second_undervolt} = 2'h3;
        step(2);
        chk(status.second_uv === 1'b0, "switching uv");
        {second_switching, can_undervolt, ext_turning_on, ext_undervolt} = 4'h7;
        step(2);
        chk(status.second_uv === 1'b1 && status.can_uv === 1'b1, "uv set");
        chk(status.ext_uv === 1'b0, "turn-on uv");
        {ext_turning_on, ext_overcurrent, second_undervolt, can_undervolt} = 4'h4;
        step(2);
        chk(status.second_uv === 1'b1 && status.can_uv === 1'b1, "uv sticky");
        chk(status.ext_uv === 1'b1 && status.ext_oc === 1'b1, "ext diag");
        {ext_overcurrent, ext_undervolt} = '0;
        u_host_model.clr('{second_uv: 1'b1, can_uv: 1'b1, default: 1'b0});
        chk(status.second_uv === 1'b0 && status.can_uv === 1'b0, "uv cleared");
        ext_hot = 1'b1;
        step(2);
        chk(ext_reg_enable_field === 2'h0 && ext_reg_on === 1'b0, "ext off");
        ext_hot = 1'b0;
        step(2);
        chk(ext_reg_on === 1'b0 && status.ext_ot === 1'b1, "ext waits");
        u_host_model.ext_reenable(2'h1);
        step(1);
        chk(ext_reg_on === 1'b1 && status.ext_ot === 1'b0, "ext again");
        {loadshare_config, ext_hot} = 2'h3;
        step(2);
        chk(ext_reg_on === 1'b0 && status.ext_ot === 1'b1, "shared ext hot");
        ext_hot = 1'b0;
        step(2);
        chk(ext_reg_on === 1'b1, "shared ext back");
        {can_tx_request, lin_one_tx_request, lin_two_tx_request} = 3'h7;
        {can_hot, lin_one_hot, lin_two_hot} = 3'h7;
        step(2);
        chk({can_tx_on, lin_one_tx_on, lin_two_tx_on} === 3'h0, "tx off");
        chk({status.can_fault, status.lin_one, status.lin_two} === 6'h15, "bus fields");
        chk(mode === fault_sup_pkg::mode_normal, "bus hot mode");
        {can_hot, lin_one_hot, lin_two_hot} = 3'h0;
        step(2);
        chk({can_tx_on, lin_one_tx_on, lin_two_tx_on} === 3'h7, "tx back");
        chk({status.can_fault, status.lin_one, status.lin_two} === 6'h15, "fields kept");
        u_host_model.wr(2, 4'hf);
        highside_hot = 4'h4;
        step(2);
        chk(highside_switches === 4'h0 && status.highside === 4'hf, "highside hot");
        highside_hot = 4'h0;
        prewarn_hot = 1'b1;
        step(2);
        chk(highside_switches === 4'h0 && status.prewarn === 1'b1, "stay off, prewarn");
        u_host_model.clr('{prewarn: 1'b1, default: 1'b0});
        chk(status.prewarn === 1'b1, "prewarn hot clear");
        prewarn_hot = 1'b0;
        u_host_model.clr('{prewarn: 1'b1, default: 1'b0});
        chk(status.prewarn === 1'b0, "prewarn cleared");
        chip_hot = 1'b1;
        step(2);
        chk(mode === fault_sup_pkg::mode_fail_safe && status.chip_tsd === 1'b1, "chip hot");
        chip_hot = 1'b0;
        u_host_model.clr('{chip_tsd: 1'b1, default: 1'b0});
        chk(status.chip_tsd === 1'b1, "clear outside normal");
        for (int n = 0; n < 20 && mode !== fault_sup_pkg::mode_normal; n++) begin
            seen |= (mode === fault_sup_pkg::mode_restart);
            step(1);
        end
        chk(seen === 1'b1 && mode === fault_sup_pkg::mode_normal, "via restart");
        u_host_model.clr('{chip_tsd: 1'b1, default: 1'b0});
        chk(status.chip_tsd === 1'b0, "chip flag cleared");
        {battery_undervolt, main_above_reset} = 2'h2;
        step(12);
        chk(mode === fault_sup_pkg::mode_normal && status.main_short === 1'b0, "uv no short");
        battery_undervolt = 1'b0;
        for (int w = 0; w < 3; w++) begin
            {main_above_reset, main_powering_up} = {1'b0, w == 0};
            step(sf - 1);
            chk(mode === fault_sup_pkg::mode_normal, "before filter");
            step(1);
            chk(mode === fault_sup_pkg::mode_fail_safe && main_reg_on === 1'b0, "short");
            chk(fail_output_pins && status.main_short == (w > 0) && status.fail, "flags");
            main_above_reset = 1'b1;
            step(6);
            chk(mode === fault_sup_pkg::mode_fail_safe, "no wake");
            {can_wake, lin_wake, wake_input_pins} = 3'h4 >> w;
            step(1);
            {can_wake, lin_wake, wake_input_pins} = 3'h0;
            for (int n = 0; n < 20 && mode !== fault_sup_pkg::mode_normal; n++) step(1);
            chk(mode === fault_sup_pkg::mode_normal && main_reg_on === 1'b1, "woken");
        end
        test_done;
    end
endmodule // tb_supply_thermal_fault_supervisor
`default_nettype wire
